// *** rtl/mcsp_pkg.sv ***
// package for the modem control and status pin block
// assumes a single 20 MHz clock domain and no register bus
// Functional notes
// - a set user output bit in the modem control register drives its pin active low.
// - user outputs go high on master reset, in loop mode, or when control bit 2 or 3 is clear.
// - the receive section is timed by a dedicated 16x receive clock input.
// - selected register data goes on the bus when chip is selected and either read strobe is active.
// - status bit 6 shows the inverse of the current ring indicator pin level when read.
// - status bit 2 is set when ring indicator rises after the previous status read.
// - with modem status interrupt enabled, a ring indicator rise raises the interrupt.
// - request-to-send follows control bit 1 and goes high on reset, loop mode, or bit clear.
// - in auto request-to-send mode the receive threshold logic forces request-to-send inactive.
// - master reset clears the registers and sets the pins to their reset levels.
package mcsp_pkg;
  // modem control register fields
  localparam int unsigned CTL_RTS_BIT = 1;
  localparam int unsigned CTL_USER_ONE_BIT = 2;
  localparam int unsigned CTL_USER_TWO_BIT = 3;
  localparam int unsigned CTL_LOOP_BIT = 4;
  // modem status register fields
  localparam int unsigned MSR_RING_EDGE_BIT = 2;
  localparam int unsigned MSR_RI_BIT = 6;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [2:0] MSR_ADDR = 3'h6;
  localparam logic [2:0] CTL_ADDR = 3'h4;
  localparam logic [7:0] BUS_IDLE = 8'h00;
  // synchroniser reset levels, matched to the idle level of each pin
  localparam logic [1:0] SYNC_LOW = 2'h0;
  localparam logic [1:0] SYNC_HIGH = 2'h3;
  localparam logic [2:0] ADDR_IDLE = 3'h0;
  localparam logic RING_PIN_IDLE = 1'h1;

  // host read bus grouped together
  typedef struct packed {
    logic chip_sel;
    logic read_strobe_low_n;
    logic read_strobe_high;
    logic [2:0] addr;
  } mcsp_rd_s;

  // pin outputs grouped together
  typedef struct packed {
    logic user_output_one_n;
    logic user_output_two_n;
    logic rts_n;
  } mcsp_pins_s;
endpackage : mcsp_pkg

// *** rtl/mcsp_top.sv ***
// modem control pins, ring indicator status and host read path
// assumes host control write port is synchronous; pins and strobes are async
`timescale 1ns/100ps
module mcsp_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // master reset pin and receive clock pin
  input wire logic master_reset_input,
  input wire logic rclk_pin,
  // host read bus
  input wire mcsp_pkg::mcsp_rd_s rd_bus,
  output logic [7:0] rd_data,
  output logic rd_data_oe_n,
  // control register write, on clk
  input wire logic mctl_wr,
  input wire logic [7:0] mctl_wdata,
  // configuration and flow control
  input wire logic msi_enable,
  input wire logic auto_rts_en,
  input wire logic rx_threshold_hit,
  // modem side
  input wire logic ring_ind_n,
  output mcsp_pkg::mcsp_pins_s pins,
  output logic modem_irq,
  output logic rx_tick_16x
);
  import mcsp_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // helpers shared by the read decode, the pin drive and the checks

  // true when the synchronised address selects the status register
  function automatic logic is_status_addr(input logic [2:0] addr);
    is_status_addr = (addr == MSR_ADDR);
  endfunction : is_status_addr

  // true when the synchronised address selects the control register
  function automatic logic is_control_addr(input logic [2:0] addr);
    is_control_addr = (addr == CTL_ADDR);
  endfunction : is_control_addr

  // active low pin level: low only while the bit is set and nothing forces it off
  function automatic logic pin_level_n(input logic bit_set, input logic force_off);
    pin_level_n = ~(bit_set & ~force_off);
  endfunction : pin_level_n

  ////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for every asynchronous input
  // reset values match each pin's idle level, so no false edge follows reset
  logic [1:0] mrst_s_q;
  logic [1:0] ri_s_q;
  logic [1:0] rclk_s_q;
  logic [1:0] rdl_s_q;
  logic [1:0] rdh_s_q;
  logic [1:0] cs_s_q;
  logic [2:0] addr_s0_q;
  logic [2:0] addr_s1_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mrst_s_q <= SYNC_LOW;
      ri_s_q <= SYNC_HIGH;
      rclk_s_q <= SYNC_LOW;
      rdl_s_q <= SYNC_HIGH;
      rdh_s_q <= SYNC_LOW;
      cs_s_q <= SYNC_LOW;
      addr_s0_q <= ADDR_IDLE;
      addr_s1_q <= ADDR_IDLE;
    end else begin
      mrst_s_q <= {mrst_s_q[0], master_reset_input};
      ri_s_q <= {ri_s_q[0], ring_ind_n};
      rclk_s_q <= {rclk_s_q[0], rclk_pin};
      rdl_s_q <= {rdl_s_q[0], rd_bus.read_strobe_low_n};
      rdh_s_q <= {rdh_s_q[0], rd_bus.read_strobe_high};
      cs_s_q <= {cs_s_q[0], rd_bus.chip_sel};
      // limitation: the host must set the address no later than the strobe
      addr_s0_q <= rd_bus.addr;
      addr_s1_q <= addr_s0_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // decode of synchronised levels
  logic ri_prev_q;
  logic rclk_prev_q;
  logic rd_prev_q;
  wire mrst_w = mrst_s_q[1];
  wire ri_w = ri_s_q[1];
  wire [2:0] addr_w = addr_s1_q;
  // either strobe reads; the host keeps the unused one inactive
  wire rd_act_w = cs_s_q[1] & (~rdl_s_q[1] | rdh_s_q[1]);
  wire rd_start_w = rd_act_w & ~rd_prev_q;
  wire msr_rd_w = rd_start_w & is_status_addr(addr_w);
  // the pin rising marks the trailing edge of a ring
  wire ri_rise_w = ri_w & ~ri_prev_q;
  // one tick per rising receive clock edge, sixteen per received bit
  assign rx_tick_16x = rclk_s_q[1] & ~rclk_prev_q;

  ////////////////////////////////////////////////////////////////////
  // previous levels for edge detection, reset to each pin's idle level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ri_prev_q <= RING_PIN_IDLE;
      rclk_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
    end else begin
      ri_prev_q <= ri_w;
      rclk_prev_q <= rclk_s_q[1];
      rd_prev_q <= rd_act_w;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // modem control register; master reset wins over a host write
  logic [7:0] mctl_q;
  wire loop_w = mctl_q[CTL_LOOP_BIT];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mctl_q <= CTL_RESET;
    end else if (mrst_w) begin
      mctl_q <= CTL_RESET;
    end else if (mctl_wr) begin
      mctl_q <= mctl_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // trailing-edge ring flag
  // a rise in the read cycle wins over the clear, so no edge is lost;
  // the cost is that such an edge shows only on the next status read
  logic ring_edge_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ring_edge_q <= 1'b0;
    end else if (mrst_w) begin
      ring_edge_q <= 1'b0;
    end else if (ri_rise_w) begin
      ring_edge_q <= 1'b1;
    end else if (msr_rd_w) begin
      ring_edge_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read multiplexer
  logic [7:0] msr_w;
  logic [7:0] rd_mux_w;
  always_comb begin
    msr_w = BUS_IDLE;
    msr_w[MSR_RI_BIT] = ~ri_w;
    msr_w[MSR_RING_EDGE_BIT] = ring_edge_q;
  end
  // unmapped addresses read as the idle byte
  assign rd_mux_w = is_status_addr(addr_w) ? msr_w :
                    is_control_addr(addr_w) ? mctl_q : BUS_IDLE;

  ////////////////////////////////////////////////////////////////////
  // read data, captured at strobe start so the host sees one stable value
  logic [7:0] rd_data_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= BUS_IDLE;
    end else if (rd_start_w) begin
      rd_data_q <= rd_mux_w;
    end
  end
  assign rd_data = rd_data_q;
  // enable follows the synchronised strobe; data settles one edge after it
  assign rd_data_oe_n = ~rd_act_w;

  ////////////////////////////////////////////////////////////////////
  // pin drive, active low, forced high by master reset or loop mode
  wire kill_w = mrst_w | loop_w;
  // receive threshold overrides the host bit to throttle the far sender
  wire throttle_w = auto_rts_en & rx_threshold_hit;
  assign pins.user_output_one_n = pin_level_n(mctl_q[CTL_USER_ONE_BIT], kill_w);
  assign pins.user_output_two_n = pin_level_n(mctl_q[CTL_USER_TWO_BIT], kill_w);
  assign pins.rts_n = pin_level_n(mctl_q[CTL_RTS_BIT], kill_w | throttle_w);
  // interrupt lives and dies with the flag
  assign modem_irq = msi_enable & ring_edge_q;

  ////////////////////////////////////////////////////////////////////
  // checks

  // a ring trailing edge while no master reset is pending
  sequence s_ring_rise;
    ri_rise_w && !mrst_w;
  endsequence
  // a status read start with no competing ring edge or master reset
  sequence s_status_read;
    msr_rd_w && !ri_rise_w && !mrst_w;
  endsequence
  // any read start that selects the status register
  sequence s_status_start;
    rd_start_w && is_status_addr(addr_w);
  endsequence

  a_user_one_drive: assert property (@(posedge clk) disable iff (rst)
    (mctl_q[CTL_USER_ONE_BIT] && !mrst_w && !loop_w) |-> !pins.user_output_one_n)
    else $error("user output one not driven active");
  a_user_two_drive: assert property (@(posedge clk) disable iff (rst)
    (mctl_q[CTL_USER_TWO_BIT] && !mrst_w && !loop_w) |-> !pins.user_output_two_n)
    else $error("user output two not driven active");
  a_user_one_forced: assert property (@(posedge clk) disable iff (rst)
    (mrst_w || loop_w || !mctl_q[CTL_USER_ONE_BIT]) |-> pins.user_output_one_n)
    else $error("user output one not inactive");
  a_user_two_forced: assert property (@(posedge clk) disable iff (rst)
    (mrst_w || loop_w || !mctl_q[CTL_USER_TWO_BIT]) |-> pins.user_output_two_n)
    else $error("user output two not inactive");
  a_rts_bit: assert property (@(posedge clk) disable iff (rst)
    (!mctl_q[CTL_RTS_BIT] || mrst_w || loop_w) |-> pins.rts_n)
    else $error("rts not inactive");
  a_rts_active: assert property (@(posedge clk) disable iff (rst)
    (mctl_q[CTL_RTS_BIT] && !mrst_w && !loop_w && !auto_rts_en) |-> !pins.rts_n)
    else $error("rts not driven active");
  a_rts_mode: assert property (@(posedge clk) disable iff (rst)
    (auto_rts_en && rx_threshold_hit) |-> pins.rts_n)
    else $error("auto rts not inactive");
  a_edge_set: assert property (@(posedge clk) disable iff (rst)
    s_ring_rise |=> ring_edge_q)
    else $error("ring edge flag missed");
  a_edge_clear: assert property (@(posedge clk) disable iff (rst)
    s_status_read |=> !ring_edge_q)
    else $error("ring edge flag not cleared");
  a_irq_raise: assert property (@(posedge clk) disable iff (rst)
    s_ring_rise ##1 msi_enable |-> modem_irq)
    else $error("modem irq missed");
  a_irq_clear: assert property (@(posedge clk) disable iff (rst)
    s_status_read |=> !modem_irq)
    else $error("modem irq not cleared");
  a_ri_level: assert property (@(posedge clk) disable iff (rst)
    s_status_start |=> rd_data[MSR_RI_BIT] == !$past(ri_w))
    else $error("ring level wrong");
  a_edge_readout: assert property (@(posedge clk) disable iff (rst)
    s_status_start |=> rd_data[MSR_RING_EDGE_BIT] == $past(ring_edge_q))
    else $error("ring edge flag read wrong");
  a_reset_clears: assert property (@(posedge clk) disable iff (rst)
    mrst_w |=> (mctl_q == CTL_RESET) && !ring_edge_q)
    else $error("master reset did not clear");
  a_bus_release: assert property (@(posedge clk) disable iff (rst)
    !cs_s_q[1] |-> rd_data_oe_n)
    else $error("bus driven while not selected");
  a_bus_drive_high: assert property (@(posedge clk) disable iff (rst)
    (cs_s_q[1] && rdh_s_q[1]) |-> !rd_data_oe_n)
    else $error("bus not driven on high strobe");
  a_bus_drive_low: assert property (@(posedge clk) disable iff (rst)
    (cs_s_q[1] && !rdl_s_q[1]) |-> !rd_data_oe_n)
    else $error("bus not driven on low strobe");
  a_data_hold: assert property (@(posedge clk) disable iff (rst)
    !rd_start_w |=> $stable(rd_data))
    else $error("read data changed without a read");
  a_tick_single: assert property (@(posedge clk) disable iff (rst)
    rx_tick_16x |=> !rx_tick_16x)
    else $error("receive tick longer than one cycle");
endmodule : mcsp_top

// *** verification/mcsp_modem_model.sv ***
// modem side model: ring indicator pin and free-running receive clock
// assumes a 16x receive clock of 200 ns, unrelated in phase to clk
`timescale 1ns/100ps
module mcsp_modem_model (
  // command from the bench
  input wire logic ring_on,
  // modem pins
  output logic ring_ind_n,
  output logic rclk_pin
);
  // ring pin is active low, so a ring shows as a low level
  assign ring_ind_n = ~ring_on;
  // receive clock runs free; odd start offset keeps it off the clk edges
  initial begin
    rclk_pin = 1'b0;
    #37;
    forever #100 rclk_pin = ~rclk_pin;
  end
endmodule : mcsp_modem_model

// *** verification/mcsp_tb.sv ***
// bench: host strobe reads, control writes and modem pin sequences
// assumes the modem model drives the ring pin and receive clock
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
  import mcsp_pkg::*;
  logic clk = 0, rst = 1, mrst = 0, wr_q = 0, msi = 0, arts = 0, thr = 0, ring = 0;
  logic oe_n, irq, tick, rclk, ri_n;
  logic [7:0] wd = 8'h00, q, d;
  mcsp_rd_s rb = '{1'b0, 1'b1, 1'b0, 3'h0};
  mcsp_pins_s pins;
  int fails = 0, n_checks = 0, cyc = 0, nt = 0, n0 = 0;
  initial forever #25 clk = ~clk;
  mcsp_modem_model i_modem (.ring_on(ring), .ring_ind_n(ri_n), .rclk_pin(rclk));
  mcsp_top i_dut (.clk(clk), .rst(rst), .master_reset_input(mrst), .rclk_pin(rclk),
    .rd_bus(rb), .rd_data(q), .rd_data_oe_n(oe_n), .mctl_wr(wr_q), .mctl_wdata(wd),
    .msi_enable(msi), .auto_rts_en(arts), .rx_threshold_hit(thr), .ring_ind_n(ri_n),
    .pins(pins), .modem_irq(irq), .rx_tick_16x(tick));
  ////////////////////////////////////////////////////////////////////////////////
  // hang limit and receive tick tally
  // ticks are counted at the falling edge, where the pulse has settled
  always @(negedge clk) begin
    if (tick === 1'b1) nt <= nt + 1;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  task automatic wr(input logic [7:0] v);
    wd = v;
    wr_q = 1'b1;
    w(1);
    wr_q = 1'b0;
    w(1);
  endtask : wr
  // strobe held until the answer is taken; gap keeps reads apart
  task automatic rd(input logic [2:0] a, input logic hi);
    int k;
    k = 0;
    rb = '{1'b1, hi, hi, a};
    while (oe_n !== 1'b0 && k < 8) begin
      w(1);
      k++;
    end
    w(2);
    d = q;
    `CHK(oe_n, 1'b0)
    rb = '{1'b0, 1'b1, 1'b0, a};
    w(5);
  endtask : rd
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    w(4);
    rst = 1'b0;
    w(3);
    `CHK(pins, 3'b111)
    wr(8'h0E);
    `CHK(pins, 3'b000)
    wr(8'h0A);
    `CHK(pins, 3'b100)
    wr(8'h06);
    `CHK(pins, 3'b010)
    wr(8'h1E);
    `CHK(pins, 3'b111)
    wr(8'h02);
    {arts, thr} = 2'b11;
    w(2);
    `CHK(pins.rts_n, 1'b1)
    arts = 1'b0;
    w(2);
    `CHK(pins.rts_n, 1'b0)
    $display("pins test done");
    wr(8'h0E);
    mrst = 1'b1;
    w(4);
    `CHK(pins, 3'b111)
    mrst = 1'b0;
    w(4);
    rd(CTL_ADDR, 1'b1);
    `CHK(d, CTL_RESET)
    rd(3'h1, 1'b0);
    `CHK(d, 8'h00)
    $display("reset test done");
    ring = 1'b1;
    w(4);
    rd(MSR_ADDR, 1'b1);
    `CHK({d[MSR_RI_BIT], d[MSR_RING_EDGE_BIT]}, 2'b10)
    ring = 1'b0;
    w(4);
    `CHK(irq, 1'b0)
    msi = 1'b1;
    w(2);
    `CHK(irq, 1'b1)
    rd(MSR_ADDR, 1'b0);
    `CHK({d[MSR_RI_BIT], d[MSR_RING_EDGE_BIT], irq}, 3'b010)
    rd(MSR_ADDR, 1'b0);
    `CHK(d[MSR_RING_EDGE_BIT], 1'b0)
    $display("ring test done");
    n0 = nt;
    w(80);
    `CHK((nt - n0) >= 19 && (nt - n0) <= 21, 1'b1)
    $display("tick test done");
    give_verdict();
  end
endmodule : tb
